// ==== design/dacc_map.svh ====
// register offsets, reset values, field positions and timing counts of the converter control
`ifndef DACC_MAP_SVH
`define DACC_MAP_SVH
`define DACC_OFS_DATA0 2'h0
`define DACC_OFS_DATA1 2'h1
`define DACC_OFS_CTRL 2'h2
`define DACC_OFS_STBY 2'h3
`define DACC_RST_DATA 8'h00
`define DACC_RST_CTRL 8'h1F
`define DACC_RST_STBY 8'hFE
`define DACC_CTRL_OE1 7
`define DACC_CTRL_OE0 6
`define DACC_CTRL_JOINT 5
`define DACC_CTRL_FIXED 8'h1F
`define DACC_STBY_RETAIN 0
`define DACC_STBY_FIXED 8'hFE
`define DACC_CONV_TIME_NS 10000
`define DACC_CLK_PERIOD_NS 50
`define DACC_CONV_CYCLES (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`endif

// ==== design/dacc_pkg.sv ====
// types shared by the converter control
package dacc_pkg;
	typedef logic [1:0] dacc_addr_t;
	typedef logic [7:0] dacc_byte_t;
	typedef enum logic [1:0]
	{
		DACC_IDLE = 2'b01,
		DACC_CONV = 2'b10
	} dacc_state_e;
	typedef struct packed
	{
		dacc_state_e st;
		logic [15:0] cnt;
		logic valid;
		dacc_byte_t result;
	} dacc_chan_s;
	typedef struct packed
	{
		dacc_byte_t data0;
		dacc_byte_t data1;
		logic oe1;
		logic oe0;
		logic joint;
		logic retain;
		dacc_byte_t rdata;
		logic stby_d;
		dacc_chan_s ch0;
		dacc_chan_s ch1;
		logic pin0_oe;
		logic pin1_oe;
		logic [1:0] sw_s;
		logic [1:0] hw_s;
	} dacc_state_s;
endpackage

// ==== design/dacc_top.sv ====
// two-channel 8-bit converter control: registers, conversion timing, pin direction, standby
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dacc_map.svh"
module dacc_top
#(
	parameter int CONV_CYCLES = `DACC_CONV_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire dacc_pkg::dacc_addr_t addr_i,
	input wire dacc_pkg::dacc_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic sw_standby_i,
	input wire logic hw_standby_i,
	output logic [7:0] analog_out_pin0_o,
	output logic analog_out_pin0_oe_o,
	output logic analog_out_pin0_valid_o,
	output logic [7:0] analog_out_pin1_o,
	output logic analog_out_pin1_oe_o,
	output logic analog_out_pin1_valid_o,
	output logic [1:0] conv_active_o
);
	import dacc_pkg::*;

	// the timer is 16 bits wide and needs at least one cycle
	if (CONV_CYCLES < 1 || CONV_CYCLES > 65535)
	begin : g_bad_conv
		$error("CONV_CYCLES out of range");
	end

	localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

	dacc_state_s q;
	dacc_state_s next_q;
	logic sw_stby;
	logic hw_stby;
	logic run0;
	logic run1;
	logic out_keep;

	// next state of one channel's conversion timer and result hold
	function automatic dacc_chan_s chan_step(input dacc_chan_s c, input logic run,
		input logic restart, input dacc_byte_t data);
		dacc_chan_s n;
		n = c;
		if (!run)
		begin
			n.st = DACC_IDLE;
			n.cnt = 16'h0000;
			n.valid = 1'b0;
		end
		else if (c.st == DACC_IDLE || restart)
		begin
			// start or restart on new data; old result held, valid cleared
			n.st = DACC_CONV;
			n.cnt = 16'h0000;
			n.valid = 1'b0;
		end
		else
		begin
			case (c.st)
				DACC_CONV:
				begin
					if (c.cnt == CONV_LAST)
					begin
						n.valid = 1'b1;
						n.result = data;
					end
					else if (!c.valid)
						n.cnt = c.cnt + 16'h0001;
				end
				default:
					n.st = DACC_IDLE;
			endcase
		end
		return n;
	endfunction

	assign sw_stby = q.sw_s[1];
	assign hw_stby = q.hw_s[1];

	always_comb
	begin
		logic enter;
		logic clear_regs;
		logic chg0;
		logic chg1;
		enter = 1'b0;
		clear_regs = 1'b0;
		chg0 = 1'b0;
		chg1 = 1'b0;
		next_q = q;
		next_q.sw_s = {q.sw_s[0], sw_standby_i};
		next_q.hw_s = {q.hw_s[0], hw_standby_i};
		next_q.stby_d = sw_stby;
		enter = sw_stby && !q.stby_d;
		clear_regs = hw_stby || (enter && !q.retain);

		if (wr_i && !hw_stby && !sw_stby)
		begin
			case (addr_i)
				`DACC_OFS_DATA0:
				begin
					chg0 = (wdata_i != q.data0);
					next_q.data0 = wdata_i;
				end
				`DACC_OFS_DATA1:
				begin
					chg1 = (wdata_i != q.data1);
					next_q.data1 = wdata_i;
				end
				`DACC_OFS_CTRL:
				begin
					// low bits are fixed and not stored
					next_q.oe1 = wdata_i[`DACC_CTRL_OE1];
					next_q.oe0 = wdata_i[`DACC_CTRL_OE0];
					next_q.joint = wdata_i[`DACC_CTRL_JOINT];
				end
				`DACC_OFS_STBY:
					next_q.retain = wdata_i[`DACC_STBY_RETAIN];
				default:
					next_q.retain = q.retain;
			endcase
		end
		if (clear_regs)
		begin
			next_q.data0 = `DACC_RST_DATA;
			next_q.data1 = `DACC_RST_DATA;
			next_q.oe1 = 1'b0;
			next_q.oe0 = 1'b0;
			next_q.joint = 1'b0;
		end
		if (hw_stby)
			next_q.retain = 1'b0;

		next_q.rdata = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				`DACC_OFS_DATA0:
					next_q.rdata = q.data0;
				`DACC_OFS_DATA1:
					next_q.rdata = q.data1;
				`DACC_OFS_CTRL:
					next_q.rdata = {q.oe1, q.oe0, q.joint, 5'h1F};
				default:
					next_q.rdata = {7'h7F, q.retain};
			endcase
		end

		// joint mode runs both channels when either enable is set
		run0 = q.oe0 || (q.joint && q.oe1);
		run1 = q.oe1 || (q.joint && q.oe0);
		next_q.ch0 = chan_step(q.ch0, run0, chg0, next_q.data0);
		next_q.ch1 = chan_step(q.ch1, run1, chg1, next_q.data1);
		if (chg0)
			next_q.ch0.result = q.ch0.result;
		if (chg1)
			next_q.ch1.result = q.ch1.result;

		out_keep = !hw_stby && (!sw_stby || q.retain);
		next_q.pin0_oe = next_q.oe0 && out_keep;
		next_q.pin1_oe = next_q.oe1 && out_keep;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= '0;
			q.data0 <= `DACC_RST_DATA;
			q.data1 <= `DACC_RST_DATA;
			q.retain <= 1'b0;
			q.ch0.st <= DACC_IDLE;
			q.ch1.st <= DACC_IDLE;
		end
		else
			q <= next_q;
	end

	assign rdata_o = q.rdata;
	assign analog_out_pin0_o = q.ch0.result;
	assign analog_out_pin1_o = q.ch1.result;
	assign analog_out_pin0_valid_o = q.ch0.valid;
	assign analog_out_pin1_valid_o = q.ch1.valid;
	assign analog_out_pin0_oe_o = q.pin0_oe;
	assign analog_out_pin1_oe_o = q.pin1_oe;
	assign conv_active_o = {q.ch1.st == DACC_CONV, q.ch0.st == DACC_CONV};

	sequence s_start0;
		$rose(q.ch0.st == DACC_CONV);
	endsequence

	sequence s_start1;
		$rose(q.ch1.st == DACC_CONV);
	endsequence

	// mirrors, for the other channel, of the single-channel checks further down, a channel 1 idle check on its own enable, and valid drop checks for both channels
	start_invalid1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_start1 |-> !q.ch1.valid)
		else $error("channel 1 valid at conversion start");

	valid_count1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(q.ch1.valid) |-> q.ch1.cnt == CONV_LAST)
		else $error("channel 1 valid before count expired");

	hold_result1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.ch1.valid && $past(q.ch1.valid) && $stable(q.data1) && q.oe1 |-> $stable(q.ch1.result))
		else $error("channel 1 result changed while held");

	pin_gate1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.pin1_oe |-> q.oe1)
		else $error("pin 1 driven without its enable");

	pin_release1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(q.oe1) |-> !q.pin1_oe)
		else $error("pin 1 still driven after enable cleared");

	joint_run0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.joint && q.oe1 |=> q.ch0.st == DACC_CONV)
		else $error("channel 0 idle in joint mode");

	solo_idle0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!q.joint && !q.oe0 |=> q.ch0.st == DACC_IDLE)
		else $error("channel 0 converting without its enable");

	solo_idle1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!q.joint && !q.oe1 |=> q.ch1.st == DACC_IDLE)
		else $error("channel 1 converting without its enable");

	restart1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `DACC_OFS_DATA1 && wdata_i != q.data1 && run1 && !sw_stby && !hw_stby
		|=> !q.ch1.valid)
		else $error("data change did not restart channel 1");

	valid_drop0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run0 |=> !q.ch0.valid)
		else $error("channel 0 valid while not running");

	valid_drop1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run1 |=> !q.ch1.valid)
		else $error("channel 1 valid while not running");

	// register access, and the hardware standby clear of channel 1 data and control
	stby_clear1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hw_stby |=> q.data1 == 8'h00 && !q.oe1 && !q.joint)
		else $error("hardware standby did not clear channel 1 and control");

	stby_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `DACC_OFS_STBY |=> rdata_o[7:1] == 7'h7F)
		else $error("fixed standby bits not read as one");

	data0_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `DACC_OFS_DATA0 |=> rdata_o == $past(q.data0))
		else $error("channel 0 data read back wrong");

	data1_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `DACC_OFS_DATA1 |=> rdata_o == $past(q.data1))
		else $error("channel 1 data read back wrong");

	ctrl_read_hi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `DACC_OFS_CTRL |=> rdata_o[7:5] == $past({q.oe1, q.oe0, q.joint}))
		else $error("control enables read back wrong");

	ctrl_write0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `DACC_OFS_CTRL && !sw_stby && !hw_stby
		|=> q.oe0 == $past(wdata_i[`DACC_CTRL_OE0]))
		else $error("channel 0 enable not written");

	ctrl_write1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `DACC_OFS_CTRL && !sw_stby && !hw_stby
		|=> q.oe1 == $past(wdata_i[`DACC_CTRL_OE1]))
		else $error("channel 1 enable not written");

	// standby behaviour, then single-channel and register checks
	sw_pins_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sw_stby && !q.retain |=> !q.pin0_oe && !q.pin1_oe)
		else $error("pins driven in software standby without retain");

	sw_pins_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sw_stby && q.retain && !hw_stby && q.oe0 |=> q.pin0_oe)
		else $error("pin 0 released in software standby with retain");

	hw_pins_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hw_stby |=> !q.pin0_oe && !q.pin1_oe)
		else $error("pins driven in hardware standby");

	pin0_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.oe0 && !wr_i && !sw_stby && !hw_stby |=> q.pin0_oe)
		else $error("pin 0 not driven while enabled");

	pin1_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.oe1 && !wr_i && !sw_stby && !hw_stby |=> q.pin1_oe)
		else $error("pin 1 not driven while enabled");

	retain_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sw_stby) && q.retain && !hw_stby |=> $stable(q.data0) && $stable(q.data1))
		else $error("data lost on software standby with retain");

	retain_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sw_stby) && q.retain && !hw_stby |=> $stable(q.oe0) && $stable(q.oe1) && $stable(q.joint))
		else $error("control lost on software standby with retain");

	entry_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sw_stby) && !q.retain |=> q.data0 == 8'h00 && q.data1 == 8'h00)
		else $error("data kept on software standby without retain");

	entry_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sw_stby) && !q.retain |=> !q.oe0 && !q.oe1 && !q.joint)
		else $error("control kept on software standby without retain");

	sw_keeps_retain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sw_stby && !hw_stby |=> q.retain == $past(q.retain))
		else $error("software standby changed the retain bit");

	hw_retain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hw_stby |=> !q.retain)
		else $error("hardware standby kept the retain bit");

	start_invalid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_start0 |-> !q.ch0.valid)
		else $error("channel 0 valid at conversion start");

	valid_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(q.ch0.valid) |-> q.ch0.cnt == CONV_LAST)
		else $error("channel 0 valid before count expired");

	hold_result_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.ch0.valid && $past(q.ch0.valid) && $stable(q.data0) && q.oe0
		|-> $stable(q.ch0.result))
		else $error("channel 0 result changed while held");

	pin_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.pin0_oe |-> q.oe0)
		else $error("pin 0 driven without its enable");

	pin_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(q.oe0) |-> !q.pin0_oe)
		else $error("pin 0 still driven after enable cleared");

	joint_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		q.joint && q.oe0 |=> q.ch1.st == DACC_CONV)
		else $error("channel 1 idle in joint mode");

	solo_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!q.joint && !q.oe1 && !q.oe0 |=> q.ch1.st == DACC_IDLE)
		else $error("channel 1 converting without enable");

	ctrl_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `DACC_OFS_CTRL |=> rdata_o[4:0] == 5'h1F)
		else $error("fixed control bits not read as one");

	stby_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hw_stby |=> q.data0 == 8'h00 && !q.retain && !q.oe0)
		else $error("hardware standby did not clear registers");

	restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `DACC_OFS_DATA0 && wdata_i != q.data0 && run0 && !sw_stby && !hw_stby
		|=> !q.ch0.valid)
		else $error("data change did not restart channel 0");
endmodule

// ==== sim/dacc_load.sv ====
// load model that watches one analog output pin
`timescale 1ns/1ps
module dacc_load
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] level_i,
	input wire logic oe_i,
	input wire logic valid_i,
	output logic [7:0] seen_o
);
	// a released pin floats, so the view keeps changing
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			seen_o <= 8'h00;
		else if (oe_i && valid_i)
			seen_o <= level_i;
		else if (!oe_i)
			seen_o <= ~seen_o;
	end
endmodule

// ==== sim/dacc_top_bench.sv ====
// register and pin scenarios for the converter control
`timescale 1ns/1ps
module dacc_top_bench;
	import dacc_pkg::*;
	logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, sw = 0, hw = 0;
	dacc_addr_t addr_i = '0;
	dacc_byte_t wdata_i = '0;
	logic [7:0] rdata_o, p0, p1, l0, l1;
	logic oe0, oe1, v0, v1;
	logic [1:0] act;
	int fails = 0, n_checks = 0;
	always #25 clk_i = ~clk_i;
	dacc_top #(.CONV_CYCLES(4)) i_dacc_top(.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sw_standby_i(sw),
		.hw_standby_i(hw), .analog_out_pin0_o(p0), .analog_out_pin0_oe_o(oe0),
		.analog_out_pin0_valid_o(v0), .analog_out_pin1_o(p1), .analog_out_pin1_oe_o(oe1),
		.analog_out_pin1_valid_o(v1), .conv_active_o(act));
	dacc_load i_dacc_load(.clk_i(clk_i), .rst_n_i(rst_n_i), .level_i(p0), .oe_i(oe0),
		.valid_i(v0), .seen_o(l0));
	dacc_load i_dacc_load_1(.clk_i(clk_i), .rst_n_i(rst_n_i), .level_i(p1), .oe_i(oe1),
		.valid_i(v1), .seen_o(l1));
	task complete_run();
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask
	task wr(input dacc_addr_t a, input dacc_byte_t d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task rd(input dacc_addr_t a, input dacc_byte_t e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		#1;
		chk("rdata", rdata_o, e);
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task wait_valid(input logic ch);
		int k;
		for (k = 0; k < 40 && (ch ? v1 : v0) !== 1'b1; k++)
			@(posedge clk_i);
		#1;
		if (k == 40)
		begin
			fails++;
			complete_run();
		end
	endtask
	initial
	begin
		idle(10);
		rst_n_i <= 1;
		rd(0, 8'h00);
		rd(1, 8'h00);
		rd(2, 8'h1F);
		rd(3, 8'hFE);
		chk("oe", {oe1, oe0}, 8'h00);
		wr(2, 8'h00);
		rd(2, 8'h1F);
		wr(3, 8'h00);
		rd(3, 8'hFE);
		wr(0, 8'h55);
		wr(2, 8'h40);
		idle(3);
		chk("oe", {oe1, oe0}, 8'h01);
		chk("act", act, 8'h01);
		wait_valid(0);
		chk("pin0", p0, 8'h55);
		idle(2);
		chk("load0", l0, 8'h55);
		wr(2, 8'h60);
		idle(3);
		chk("act", act, 8'h03);
		chk("oe", {oe1, oe0}, 8'h01);
		wr(0, 8'hAA);
		idle(2);
		chk("valid0", v0, 8'h00);
		chk("pin0", p0, 8'h55);
		wait_valid(0);
		chk("pin0", p0, 8'hAA);
		wr(1, 8'h33);
		wr(2, 8'h80);
		idle(3);
		chk("oe", {oe1, oe0}, 8'h02);
		chk("act", act, 8'h02);
		wait_valid(1);
		chk("pin1", p1, 8'h33);
		idle(2);
		chk("load1", l1, 8'h33);
		sw <= 1;
		idle(6);
		chk("oe", {oe1, oe0}, 8'h00);
		sw <= 0;
		idle(4);
		rd(1, 8'h00);
		rd(2, 8'h1F);
		wr(1, 8'h77);
		wr(2, 8'h80);
		wr(3, 8'h01);
		idle(2);
		sw <= 1;
		idle(6);
		chk("oe", {oe1, oe0}, 8'h02);
		sw <= 0;
		idle(4);
		rd(1, 8'h77);
		rd(2, 8'h9F);
		rd(3, 8'hFF);
		hw <= 1;
		idle(6);
		hw <= 0;
		idle(4);
		rd(3, 8'hFE);
		rd(2, 8'h1F);
		rd(1, 8'h00);
		complete_run();
	end
endmodule
